//--- rtl/ast_pkg.sv
// Package for the A/D start trigger selector: register map, field layout, reset values.
// Assumes a single 250 MHz core clock and a plain strobe register port.
package ast_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] OFF_SEL_A = 4'h0;
  localparam logic [3:0] OFF_SEL_B = 4'h1;
  localparam logic [3:0] OFF_CTRL = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;
  localparam logic [3:0] OFF_SLV_CNT_L = 4'h4;
  localparam logic [3:0] OFF_SLV_CNT_H = 4'h5;
  // Field positions in a select register
  localparam int SEL_UNDERFLOW = 0;
  localparam int SEL_CYCLE = 1;
  localparam int SEL_SLAVE_A = 2;
  localparam int SEL_SLAVE_B = 3;
  localparam int DMASK_A = 4;
  localparam int DMASK_B = 5;
  // Field positions in the control register
  localparam int CTRL_TUNED = 0;
  localparam int CTRL_CREST_EN = 1;
  localparam int CTRL_VALLEY_EN = 2;
  localparam int CTRL_OUT0_LEVEL = 3;
  localparam int CTRL_OUT0_OE = 4;
  // Reset values
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cycle;
    logic tick;
    logic underflow;
    logic cycle_match;
    logic pos_phase;
  } ast_master_t;

  typedef struct packed {
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_b;
  } ast_slave_cfg_t;
endpackage : ast_pkg

//--- rtl/ast_trigger_select.sv
// A/D start trigger selector with the tuned slave up-counter.
// Assumes master timer signals are synchronous to core_clk; tick is a one-cycle enable.
// Function
// - Slave counts up, clears at master cycle
// - Slave equals master up; counts up otherwise
// - Two outputs, four select bits each
// - Select bit 0 picks master underflow
// - Select bit 1 picks master cycle match
// - Select bit 2 picks masked slave A match
// - Select bit 3 picks masked slave B match
// - Master sources gated by crest/valley enables
// - Slave A mask picks up or down
// - Slave B mask picks up or down
// - Select bits act immediately, no buffering
// - Direction comes from positive phase output
// - Up period: zero compare fires at 0000H
// - Down period: zero compare fires at M+1
// - Compare above M never fires
// - Slave advances on master tick
// - No crest/valley without output 0 enabled
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module ast_trigger_select (
  input wire logic core_clk, // 250 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire ast_pkg::ast_master_t master, // Master timer state and events
  input wire ast_pkg::ast_slave_cfg_t slave_cfg, // Slave compare values
  input wire logic [ast_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic [ast_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [ast_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  output logic adc0_start_trigger, // Start pulse to converter 0
  output logic adc1_start_trigger, // Start pulse to converter 1
  output logic [ast_pkg::CNT_W-1:0] slave_count // Slave counter value
);
  logic [7:0] trigger_select_reg_a;
  logic [7:0] trigger_select_reg_b;
  logic [7:0] ctrl;
  logic [7:0] next_sel_a;
  logic [7:0] next_sel_b;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic [ast_pkg::CNT_W-1:0] next_slave_count;
  logic next_trig0;
  logic next_trig1;
  logic slave_match_a_event;
  logic slave_match_b_event;
  logic master_underflow_event;
  logic master_cycle_match_event;
  logic count_direction_flag;
  logic pos_enabled;
  logic [1:0] sticky_trig;
  logic [1:0] next_sticky;

  // Register writes and reads
  always_comb begin
    next_sel_a = trigger_select_reg_a;
    next_sel_b = trigger_select_reg_b;
    next_ctrl = ctrl;
    next_rdata = 8'h00;
    next_sticky = sticky_trig | {next_trig1, next_trig0};
    if (reg_wr) begin
      case (reg_addr)
        ast_pkg::OFF_SEL_A: next_sel_a = {2'b00, reg_wdata[5:0]};
        ast_pkg::OFF_SEL_B: next_sel_b = {2'b00, reg_wdata[5:0]};
        ast_pkg::OFF_CTRL: next_ctrl = {3'b000, reg_wdata[4:0]};
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ast_pkg::OFF_SEL_A: next_rdata = trigger_select_reg_a;
        ast_pkg::OFF_SEL_B: next_rdata = trigger_select_reg_b;
        ast_pkg::OFF_CTRL: next_rdata = ctrl;
        ast_pkg::OFF_STATUS: next_rdata = {5'b00000, count_direction_flag, sticky_trig};
        ast_pkg::OFF_SLV_CNT_L: next_rdata = slave_count[7:0];
        ast_pkg::OFF_SLV_CNT_H: next_rdata = slave_count[15:8];
        default: next_rdata = 8'h00;
      endcase
      // Reading status clears the seen-trigger bits; a new pulse wins
      if (reg_addr == ast_pkg::OFF_STATUS) begin
        next_sticky = {next_trig1, next_trig0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_select_reg_a <= ast_pkg::SEL_RESET;
      trigger_select_reg_b <= ast_pkg::SEL_RESET;
      ctrl <= ast_pkg::CTRL_RESET;
      reg_rdata <= 8'h00;
      sticky_trig <= 2'b00;
    end else begin
      trigger_select_reg_a <= next_sel_a;
      trigger_select_reg_b <= next_sel_b;
      ctrl <= next_ctrl;
      reg_rdata <= next_rdata;
      sticky_trig <= next_sticky;
    end
  end

  // Direction and master event qualification
  always_comb begin
    pos_enabled = !ctrl[ast_pkg::CTRL_OUT0_LEVEL] && ctrl[ast_pkg::CTRL_OUT0_OE];
    // Positive phase high while counting down; low when disabled
    count_direction_flag = pos_enabled && master.pos_phase;
    master_underflow_event = master.underflow && pos_enabled
                             && ctrl[ast_pkg::CTRL_VALLEY_EN];
    master_cycle_match_event = master.cycle_match && pos_enabled
                               && ctrl[ast_pkg::CTRL_CREST_EN];
  end

  // Slave counter tracks the master tick
  always_comb begin
    next_slave_count = slave_count;
    if (!ctrl[ast_pkg::CTRL_TUNED]) begin
      next_slave_count = ast_pkg::CNT_RESET;
    end else if (master.tick) begin
      if (slave_count >= master.cycle) begin
        next_slave_count = ast_pkg::CNT_RESET;
      end else begin
        next_slave_count = slave_count + ast_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_count <= ast_pkg::CNT_RESET;
    end else begin
      slave_count <= next_slave_count;
    end
  end

  // Slave matches fire once per tick while tuned; values above M are never reached
  always_comb begin
    slave_match_a_event = ctrl[ast_pkg::CTRL_TUNED] && master.tick
                          && (slave_count == slave_cfg.cmp_a);
    slave_match_b_event = ctrl[ast_pkg::CTRL_TUNED] && master.tick
                          && (slave_count == slave_cfg.cmp_b);
  end

  function automatic logic ast_pick(input logic [7:0] sel, input logic uf, input logic cm,
                                    input logic ma, input logic mb, input logic dir);
    logic a_ok;
    logic b_ok;
    a_ok = ma && (sel[ast_pkg::DMASK_A] == dir);
    b_ok = mb && (sel[ast_pkg::DMASK_B] == dir);
    ast_pick = (sel[ast_pkg::SEL_UNDERFLOW] && uf)
               || (sel[ast_pkg::SEL_CYCLE] && cm)
               || (sel[ast_pkg::SEL_SLAVE_A] && a_ok)
               || (sel[ast_pkg::SEL_SLAVE_B] && b_ok);
  endfunction : ast_pick

  always_comb begin
    next_trig0 = ast_pick(trigger_select_reg_a, master_underflow_event,
                          master_cycle_match_event, slave_match_a_event,
                          slave_match_b_event, count_direction_flag);
    next_trig1 = ast_pick(trigger_select_reg_b, master_underflow_event,
                          master_cycle_match_event, slave_match_a_event,
                          slave_match_b_event, count_direction_flag);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc0_start_trigger <= 1'b0;
      adc1_start_trigger <= 1'b0;
    end else begin
      adc0_start_trigger <= next_trig0;
      adc1_start_trigger <= next_trig1;
    end
  end

  // Checks
  underflow_select_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (master.underflow && pos_enabled && ctrl[ast_pkg::CTRL_VALLEY_EN]
     && trigger_select_reg_a[ast_pkg::SEL_UNDERFLOW]) |=> adc0_start_trigger)
    else $error("underflow did not trigger output 0");

  underflow_out1_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (master.underflow && pos_enabled && ctrl[ast_pkg::CTRL_VALLEY_EN]
     && trigger_select_reg_b[ast_pkg::SEL_UNDERFLOW]) |=> adc1_start_trigger)
    else $error("underflow did not trigger output 1");

  cycle_select_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (master.cycle_match && pos_enabled && ctrl[ast_pkg::CTRL_CREST_EN]
     && trigger_select_reg_b[ast_pkg::SEL_CYCLE]) |=> adc1_start_trigger)
    else $error("cycle match did not trigger output 1");

  cycle_out0_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (master.cycle_match && pos_enabled && ctrl[ast_pkg::CTRL_CREST_EN]
     && trigger_select_reg_a[ast_pkg::SEL_CYCLE]) |=> adc0_start_trigger)
    else $error("cycle match did not trigger output 0");

  cull_gate_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!pos_enabled && !slave_match_a_event && !slave_match_b_event)
    |=> !adc0_start_trigger && !adc1_start_trigger)
    else $error("master source passed without output 0 enabled");

  valley_gate_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (master.underflow && !ctrl[ast_pkg::CTRL_VALLEY_EN] && trigger_select_reg_a == 8'h01)
    |=> !adc0_start_trigger)
    else $error("underflow passed with valley interrupt off");

  crest_gate_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (master.cycle_match && !pos_enabled && !slave_match_a_event
     && trigger_select_reg_a == 8'h06) |=> !adc0_start_trigger)
    else $error("cycle match passed with output 0 disabled");

  mask_slave_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (slave_match_a_event && trigger_select_reg_a == 8'h04 && count_direction_flag)
    |=> !adc0_start_trigger)
    else $error("slave A passed while counting down with mask 0");

  mask_up_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (slave_match_a_event && trigger_select_reg_b == 8'h14 && !count_direction_flag)
    |=> !adc1_start_trigger)
    else $error("slave A passed while counting up with mask 1");

  slave_pass_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (slave_match_a_event && trigger_select_reg_a == 8'h04 && !count_direction_flag)
    |=> adc0_start_trigger)
    else $error("slave A up match missing on output 0");

  mask_slave_b: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (slave_match_b_event && trigger_select_reg_b == 8'h28 && count_direction_flag)
    |=> adc1_start_trigger)
    else $error("slave B down match missing on output 1");

  mask_up_b: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (slave_match_b_event && trigger_select_reg_b == 8'h28 && !count_direction_flag)
    |=> !adc1_start_trigger)
    else $error("slave B passed while counting up with mask 1");

  mask_down_b: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (slave_match_b_event && trigger_select_reg_a == 8'h08 && count_direction_flag)
    |=> !adc0_start_trigger)
    else $error("slave B passed while counting down with mask 0");

  slave_pass_b: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (slave_match_b_event && trigger_select_reg_a == 8'h08 && !count_direction_flag)
    |=> adc0_start_trigger)
    else $error("slave B up match missing on output 0");

  slave_clear_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ctrl[ast_pkg::CTRL_TUNED] && master.tick && slave_count == master.cycle)
    |=> slave_count == ast_pkg::CNT_RESET)
    else $error("slave counter did not clear at cycle value");

  slave_up_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ctrl[ast_pkg::CTRL_TUNED] && master.tick && slave_count < master.cycle)
    |=> slave_count == $past(slave_count) + ast_pkg::CNT_ONE)
    else $error("slave counter did not step up");

  untuned_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !ctrl[ast_pkg::CTRL_TUNED]
    |=> slave_count == ast_pkg::CNT_RESET)
    else $error("slave counter not held at zero untuned");

  slave_track_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ctrl[ast_pkg::CTRL_TUNED] && !master.pos_phase)
    |-> slave_count == master.count)
    else $error("slave count differs from master while counting up");

  slave_step_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ctrl[ast_pkg::CTRL_TUNED] && !master.tick)
    |=> $stable(slave_count))
    else $error("slave counter moved without master tick");

  cmp_high_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (slave_cfg.cmp_a > master.cycle)
    |-> !slave_match_a_event)
    else $error("compare above cycle value matched");

  pulse_source_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(adc0_start_trigger)
    |-> $past(trigger_select_reg_a[3:0]) != 4'h0)
    else $error("output 0 pulsed with nothing selected");

  merge_pulse_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (master_underflow_event && slave_match_a_event && trigger_select_reg_a == 8'h05)
    |=> adc0_start_trigger ##1 !adc0_start_trigger)
    else $error("simultaneous sources did not merge into one pulse");

  reset_idle_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (trigger_select_reg_a == 8'h00)
    |=> !adc0_start_trigger)
    else $error("output 0 pulsed with empty select");

  immediate_sel_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == ast_pkg::OFF_SEL_A)
    |=> trigger_select_reg_a == {2'b00, $past(reg_wdata[5:0])})
    else $error("select write not applied at once");
endmodule : ast_trigger_select

//--- verification/ast_master_model.sv
// Master timer model: triangle count 0000H..M+1..0001H, one tick per clock while run is high.
// Assumes it shares core_clk and rst_n with the trigger selector.
`timescale 1ns/1ps
module ast_master_model #(
  parameter int M = 4
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic run, // Count enable
  output ast_pkg::ast_master_t master, // Timer state to the selector
  output logic [7:0] phase // Position in the period
);
  logic [7:0] next_phase;
  always_comb begin
    next_phase = (phase == 8'(2 * M + 1)) ? 8'h00 : phase + 8'h01;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 8'h00;
    end else if (run) begin
      phase <= next_phase;
    end
  end
  always_comb begin
    master = '0;
    master.count = (phase <= 8'(M + 1)) ? 16'(phase) : 16'(2 * M + 2 - phase);
    master.cycle = 16'(M);
    master.tick = run;
    master.underflow = run && (phase == 8'h00);
    master.cycle_match = run && (phase == 8'(M + 1));
    master.pos_phase = (phase > 8'(M));
  end
endmodule : ast_master_model

//--- verification/tb_adc_start_trigger_select.sv
// Testbench for the A/D start trigger selector: register tasks and pulse counts per window.
// Assumes the master model runs the triangle with M = 4, so one period is 10 cycles.
`timescale 1ns/1ps
module tb_adc_start_trigger_select;
  localparam int M = 4;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  ast_pkg::ast_master_t master;
  ast_pkg::ast_slave_cfg_t slave_cfg = '0;
  logic [ast_pkg::ADDR_W-1:0] reg_addr = 4'h0;
  logic [ast_pkg::DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ast_pkg::DATA_W-1:0] reg_rdata;
  logic adc0_start_trigger;
  logic adc1_start_trigger;
  logic [15:0] slave_count;
  logic [7:0] phase;
  int fail_count = 0;
  int checked = 0;
  always #2 core_clk = ~core_clk;
  ast_master_model #(.M(M)) u_master (.core_clk(core_clk), .rst_n(rst_n), .run(run),
    .master(master), .phase(phase));
  ast_trigger_select u_dut (.core_clk(core_clk), .rst_n(rst_n), .master(master),
    .slave_cfg(slave_cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc0_start_trigger(adc0_start_trigger),
    .adc1_start_trigger(adc1_start_trigger), .slave_count(slave_count));
  task automatic summarize;
    $display("checks=%0d errors=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  // Counts trigger cycles over four whole master periods
  task automatic scen(input logic [7:0] c, input logic [7:0] s0, input logic [7:0] s1,
    input logic [15:0] ca, input logic [15:0] cb, input int e0, input int e1);
    int n0;
    int n1;
    n0 = 0;
    n1 = 0;
    wr(4'h2, c);
    wr(4'h0, s0);
    wr(4'h1, s1);
    slave_cfg <= '{cmp_a: ca, cmp_b: cb};
    repeat (3) @(posedge core_clk);
    repeat (8 * M + 8) begin
      @(negedge core_clk);
      if (adc0_start_trigger === 1'b1) n0++;
      if (adc1_start_trigger === 1'b1) n1++;
    end
    chk(16'(n0), 16'(e0));
    chk(16'(n1), 16'(e1));
  endtask : scen
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h3F);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h17);
    run <= 1'b1;
    repeat (2 * M + 2) begin
      @(negedge core_clk);
      chk(slave_count, 16'(phase % (M + 1)));
    end
    scen(8'h17, 8'h01, 8'h02, 16'h0000, 16'h0000, 4, 4);
    scen(8'h17, 8'h04, 8'h14, 16'h0002, 16'h0000, 4, 4);
    scen(8'h17, 8'h08, 8'h28, 16'h0000, 16'h0000, 4, 4);
    scen(8'h17, 8'h04, 8'h14, 16'(M), 16'h0000, 4, 4);
    scen(8'h17, 8'h04, 8'h08, 16'(M + 1), 16'(M + 1), 0, 0);
    scen(8'h17, 8'h05, 8'h03, 16'h0000, 16'h0000, 4, 8);
    scen(8'h17, 8'h0F, 8'h3F, 16'h0001, 16'h0003, 16, 16);
    scen(8'h13, 8'h01, 8'h02, 16'h0000, 16'h0000, 0, 4);
    scen(8'h1F, 8'h06, 8'h14, 16'h0002, 16'h0000, 8, 0);
    scen(8'h16, 8'h04, 8'h08, 16'h0002, 16'h0000, 0, 0);
    wr(4'h2, 8'h08);
    rd(4'h3, 8'h03);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h5, 8'h00);
    summarize();
  end
endmodule : tb_adc_start_trigger_select
